// *** pkg/des_pkg.sv ***
// package for the dma event status and interrupt mask block
// assumes a single core clock and an apb register bus with 32-bit data
package des_pkg;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam int          DES_ADDR_W       = 8;
    localparam logic [7:0]  DES_OFF_STATUS   = 8'h28;
    localparam logic [7:0]  DES_OFF_MASK     = 8'h2C;
    localparam logic [7:0]  DES_OFF_QCTRL    = 8'h40;
    localparam logic [7:0]  DES_OFF_PENDING  = 8'h44;

    // ------------------------------------------------------------
    // status and mask bit positions
    // ------------------------------------------------------------
    localparam int DES_B_RX_CRC        = 2;
    localparam int DES_B_RX_ABORT      = 3;
    localparam int DES_B_RX_LEN        = 4;
    localparam int DES_B_RX_OVFL       = 5;
    localparam int DES_B_LFQ_READ      = 6;
    localparam int DES_B_LFQ_EMPTY     = 7;
    localparam int DES_B_SFQ_READ      = 8;
    localparam int DES_B_SFQ_EMPTY     = 9;
    localparam int DES_B_RX_DQ_WR      = 10;
    localparam int DES_B_RX_DQ_FULL    = 11;
    localparam int DES_B_TX_UDFL       = 12;
    localparam int DES_B_TX_PQ_READ    = 13;
    localparam int DES_B_TX_DQ_WR      = 14;
    localparam int DES_B_TX_DQ_FULL    = 15;
    localparam logic [15:0] DES_EVT_BITS   = 16'hFFFC;
    localparam logic [15:0] DES_STATUS_RST = 16'h0000;
    localparam logic [15:0] DES_MASK_RST   = 16'h0000;

    // ------------------------------------------------------------
    // queue control register fields
    // ------------------------------------------------------------
    localparam int          DES_QC_TX_THR_LSB = 0;
    localparam int          DES_QC_RX_THR_LSB = 4;
    localparam int          DES_QC_LCFG       = 8;
    localparam int          DES_THR_W         = 3;
    localparam int          DES_CNT_W         = 7;
    localparam logic [2:0]  DES_THR_RST       = 3'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic tx_done_queue_full_error;
        logic tx_done_queue_written;
        logic tx_pending_queue_read;
        logic tx_fifo_underflow;
        logic rx_done_queue_full_error;
        logic rx_done_queue_written;
        logic small_free_queue_empty_error;
        logic small_free_queue_read;
        logic large_free_queue_empty_error;
        logic large_free_queue_read;
        logic rx_fifo_overflow;
        logic rx_len_over_max;
        logic rx_len_under_min;
        logic rx_len_non_octet;
        logic rx_abort_seen;
        logic rx_crc_error;
    } des_evt_t;

    typedef struct packed {
        logic [DES_CNT_W-1:0] cnt;
    } des_thr_state_t;

    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] status;
        logic [2:0]  tx_thr;
        logic [2:0]  rx_thr;
        logic        lcfg;
        logic [31:0] rdata;
        logic        slverr;
        logic        rd_stat;
    } des_state_t;

    localparam des_state_t DES_STATE_RST = '{
        mask:    DES_MASK_RST,
        status:  DES_STATUS_RST,
        tx_thr:  DES_THR_RST,
        rx_thr:  DES_THR_RST,
        lcfg:    1'b0,
        rdata:   32'h0000_0000,
        slverr:  1'b0,
        rd_stat: 1'b0
    };

endpackage

// *** core/des_thresh.sv ***
// done-queue write threshold counter
// assumes one write pulse per cycle at most, synchronous to clk_i
module des_thresh
    import des_pkg::*;
#(
    parameter int CNT_W = DES_CNT_W
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [2:0]       thr_i,
    input  wire logic             restart_i,
    input  wire logic             wr_i,
    output logic                  fire_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    des_thr_state_t s_r;
    des_thr_state_t s_nxt;
    logic [CNT_W:0] limit;

    // 0 means every write, n means 2**n writes (2 to 128)
    assign limit = (CNT_W+1)'(1) << thr_i;

    always_comb begin
        s_nxt  = s_r;
        fire_o = 1'b0;
        if (restart_i) begin
            // a new threshold starts a fresh count
            s_nxt.cnt = '0;
        end else if (wr_i) begin
            if (thr_i == 3'h0 || {1'b0, s_r.cnt} == limit - (CNT_W+1)'(1)) begin
                fire_o    = 1'b1;
                s_nxt.cnt = '0;
            end else begin
                s_nxt.cnt = s_r.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // des_thresh

// *** core/des_top.sv ***
// dma event status collector with interrupt mask, apb slave
// assumes event inputs are one-cycle pulses synchronous to clk_i
// and that the apb master keeps to the apb protocol

// Overview of operation
// - rx done queue full write sets bit 11
// - any tx fifo underflow sets bit 12
// - tx pending queue read sets bit 13
// - tx done writes set bit 14 via threshold
// - tx done queue full write sets bit 15
// - status bits clear on read, set by new event
// - unmasked set flag drives host irq, and local irq when lcfg is set
// - mask bits 2..15 match status, 1 unmasks
// - mask bits read/write, reset to zero
// - crc error bit 2, abort bit 3
// - length violation bit 4, rx overflow bit 5
// - free queue reads and empty errors bits 6..9
module des_top
    import des_pkg::*;
#(
    parameter int ADDR_W = DES_ADDR_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic                   pready_o,
    output logic [31:0]            prdata_o,
    output logic                   pslverr_o,
    // events from the dma engines and fifos
    input  wire des_evt_t          evt_i,
    // interrupts
    output logic                   host_bus_irq_n_o,
    output logic                   local_bus_irq_n_o
);

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    des_state_t  s_r;
    des_state_t  s_nxt;

    logic        setup;
    logic        access;
    logic        wr_acc;
    logic        rd_setup;
    logic        hit_status;
    logic        hit_mask;
    logic        hit_qctrl;
    logic        hit_pending;
    logic        hit_any;
    logic [15:0] wmask;
    logic [15:0] wdata16;
    logic        qctrl_wr;
    logic        rx_dq_fire;
    logic        tx_dq_fire;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] pending;

    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i;
    assign wr_acc   = access & pwrite_i;
    assign rd_setup = setup & ~pwrite_i;

    // zero wait states: every access completes in its first access cycle
    assign pready_o = access;

    assign hit_status  = (paddr_i == ADDR_W'(DES_OFF_STATUS));
    assign hit_mask    = (paddr_i == ADDR_W'(DES_OFF_MASK));
    assign hit_qctrl   = (paddr_i == ADDR_W'(DES_OFF_QCTRL));
    assign hit_pending = (paddr_i == ADDR_W'(DES_OFF_PENDING));
    assign hit_any     = hit_status | hit_mask | hit_qctrl | hit_pending;

    // byte lanes 0 and 1 cover the 16-bit registers
    assign wmask   = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign wdata16 = pwdata_i[15:0] & wmask;

    assign qctrl_wr = wr_acc & hit_qctrl;

    // ------------------------------------------------------------
    // done-queue write thresholds
    // ------------------------------------------------------------
    des_thresh #(
        .CNT_W     (DES_CNT_W)
    ) u_rx_thr (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .thr_i     (s_r.rx_thr),
        .restart_i (qctrl_wr),
        .wr_i      (evt_i.rx_done_queue_written),
        .fire_o    (rx_dq_fire)
    );

    des_thresh #(
        .CNT_W     (DES_CNT_W)
    ) u_tx_thr (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .thr_i     (s_r.tx_thr),
        .restart_i (qctrl_wr),
        .wr_i      (evt_i.tx_done_queue_written),
        .fire_o    (tx_dq_fire)
    );

    // ------------------------------------------------------------
    // event set vector
    // ------------------------------------------------------------
    always_comb begin
        set_vec                   = 16'h0000;
        set_vec[DES_B_RX_CRC]     = evt_i.rx_crc_error;
        set_vec[DES_B_RX_ABORT]   = evt_i.rx_abort_seen;
        set_vec[DES_B_RX_LEN]     = evt_i.rx_len_over_max
                                  | evt_i.rx_len_under_min
                                  | evt_i.rx_len_non_octet;
        set_vec[DES_B_RX_OVFL]    = evt_i.rx_fifo_overflow;
        set_vec[DES_B_LFQ_READ]   = evt_i.large_free_queue_read;
        set_vec[DES_B_LFQ_EMPTY]  = evt_i.large_free_queue_empty_error;
        set_vec[DES_B_SFQ_READ]   = evt_i.small_free_queue_read;
        set_vec[DES_B_SFQ_EMPTY]  = evt_i.small_free_queue_empty_error;
        set_vec[DES_B_RX_DQ_WR]   = rx_dq_fire;
        set_vec[DES_B_RX_DQ_FULL] = evt_i.rx_done_queue_full_error;
        set_vec[DES_B_TX_UDFL]    = evt_i.tx_fifo_underflow;
        set_vec[DES_B_TX_PQ_READ] = evt_i.tx_pending_queue_read;
        set_vec[DES_B_TX_DQ_WR]   = tx_dq_fire;
        set_vec[DES_B_TX_DQ_FULL] = evt_i.tx_done_queue_full_error;
    end

    // ------------------------------------------------------------
    // clear vector
    // ------------------------------------------------------------
    // only bits actually returned to software are cleared, so an event
    // landing between setup and access is not lost
    always_comb begin
        clr_vec = 16'h0000;
        if (access & ~pwrite_i & s_r.rd_stat) begin
            clr_vec = s_r.rdata[15:0];
        end
        if (wr_acc & hit_status) begin
            clr_vec = clr_vec | wdata16;
        end
    end

    assign pending = s_r.status & s_r.mask;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // set wins over clear in the same cycle
        s_nxt.status = ((s_r.status & ~clr_vec) | set_vec) & DES_EVT_BITS;

        if (wr_acc & hit_mask) begin
            // bits 1 and 0 are unused and stay zero
            s_nxt.mask = ((s_r.mask & ~wmask) | wdata16) & DES_EVT_BITS;
        end

        if (qctrl_wr) begin
            if (pstrb_i[0]) begin
                s_nxt.tx_thr = pwdata_i[DES_QC_TX_THR_LSB +: DES_THR_W];
                s_nxt.rx_thr = pwdata_i[DES_QC_RX_THR_LSB +: DES_THR_W];
            end
            if (pstrb_i[1]) begin
                s_nxt.lcfg = pwdata_i[DES_QC_LCFG];
            end
        end

        if (setup) begin
            s_nxt.slverr  = ~hit_any;
            s_nxt.rd_stat = rd_setup & hit_status;
            s_nxt.rdata   = 32'h0000_0000;
            if (rd_setup) begin
                case (1'b1)
                    hit_status: begin
                        s_nxt.rdata[15:0] = s_r.status;
                    end
                    hit_mask: begin
                        s_nxt.rdata[15:0] = s_r.mask;
                    end
                    hit_qctrl: begin
                        s_nxt.rdata[DES_QC_TX_THR_LSB +: DES_THR_W] = s_r.tx_thr;
                        s_nxt.rdata[DES_QC_RX_THR_LSB +: DES_THR_W] = s_r.rx_thr;
                        s_nxt.rdata[DES_QC_LCFG]                    = s_r.lcfg;
                    end
                    hit_pending: begin
                        s_nxt.rdata[15:0] = pending;
                    end
                    default: begin
                        s_nxt.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end else if (access) begin
            // one read clears once only
            s_nxt.rd_stat = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r <= DES_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata_o  = s_r.rdata;
    assign pslverr_o = s_r.slverr & access;

    // level outputs, combinational from the status, mask and lcfg registers, active low
    assign host_bus_irq_n_o  = ~(|pending);
    assign local_bus_irq_n_o = ~((|pending) & s_r.lcfg);

endmodule // des_top

// *** test/des_properties.sv ***
// checker: status, mask and irq relations of des_top
// assumes a bind to des_top and an apb master keeping the protocol
module des_properties
    import des_pkg::*;
#(
    parameter int ADDR_W = DES_ADDR_W
) (
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic              pready_o,
    input wire logic [31:0]       prdata_o,
    input wire logic              pslverr_o,
    input wire des_evt_t          evt_i,
    input wire logic              host_bus_irq_n_o,
    input wire logic              local_bus_irq_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [15:0] ev, msk_r, need_r, pend_r, seen_r, acc_r;
    logic        acc, mwr, swr, rds, sset, wr_r;
    assign ev   = {evt_i[15:5], |evt_i[4:2], evt_i[1:0], 2'b00};
    assign acc  = psel_i & penable_i;
    assign mwr  = acc & pwrite_i & (paddr_i == DES_OFF_MASK);
    assign swr  = acc & pwrite_i & (paddr_i == DES_OFF_STATUS);
    assign rds  = acc & !pwrite_i & (paddr_i == DES_OFF_STATUS);
    assign sset = psel_i & !penable_i & !pwrite_i & (paddr_i == DES_OFF_STATUS);
    // threshold bits 10 and 14 left out: they need several writes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            msk_r  <= 16'h0000;
            need_r <= 16'h0000;
            pend_r <= 16'h0000;
            seen_r <= 16'h0000;
            acc_r  <= 16'h0000;
            wr_r   <= 1'b0;
        end else begin
            wr_r <= wr_r | (acc & pwrite_i);
            if (mwr) begin
                msk_r <= {pstrb_i[1] ? pwdata_i[15:8] : msk_r[15:8],
                          pstrb_i[0] ? pwdata_i[7:0] : msk_r[7:0]};
            end
            if (sset) begin
                need_r <= pend_r;
                pend_r <= ev & 16'hBBFC;
            end else begin
                pend_r <= (pend_r & ~(swr ? pwdata_i[15:0] : 16'h0000)) | (ev & 16'hBBFC);
            end
            if (rds) begin
                seen_r <= prdata_o[15:0];
                acc_r  <= ev;
            end else begin
                acc_r <= acc_r | ev;
            end
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_stat_rd;
        sset ##1 rds;
    endsequence
    sequence s_mask_rd;
        psel_i && !penable_i && !pwrite_i && paddr_i == DES_OFF_MASK ##1 acc;
    endsequence
    AST_EVT_SETS: assert property (
        s_stat_rd |-> (need_r & ~prdata_o[15:0]) == 16'h0000)
        else $error("event missing from status read");
    AST_READ_CLEARS: assert property (
        rds |-> (prdata_o[15:0] & seen_r & ~acc_r) == 16'h0000)
        else $error("status bit survived its read");
    AST_MASK_RB: assert property (
        s_mask_rd |-> prdata_o == {16'h0000, msk_r & DES_EVT_BITS})
        else $error("mask readback wrong");
    AST_UNUSED: assert property (
        rds |-> prdata_o[31:16] == 16'h0000 && prdata_o[1:0] == 2'b00)
        else $error("unused status bits set");
    AST_IRQ_EVT: assert property (
        (|(ev & msk_r & 16'hBBFC)) && !mwr |=> !host_bus_irq_n_o)
        else $error("unmasked event gave no irq");
    AST_LOCAL: assert property (
        !local_bus_irq_n_o |-> !host_bus_irq_n_o)
        else $error("local irq without host irq");
    AST_IRQ_HELD: assert property (
        !host_bus_irq_n_o |=> !host_bus_irq_n_o || $past(acc))
        else $error("irq dropped without access");
    AST_IRQ_RESET: assert property (
        !wr_r |-> host_bus_irq_n_o && local_bus_irq_n_o)
        else $error("irq before any mask write");
endmodule // des_properties

bind des_top des_properties #(.ADDR_W(ADDR_W)) u_des_properties (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .evt_i(evt_i),
    .host_bus_irq_n_o(host_bus_irq_n_o), .local_bus_irq_n_o(local_bus_irq_n_o));

// *** test/des_host_model.sv ***
// apb master standing in for host software
// assumes the slave answers with pready at a rising edge
module des_host_model
    import des_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  pready_i,
    input  wire logic [31:0]           prdata_i,
    input  wire logic                  pslverr_i,
    output logic                       psel_o,
    output logic                       penable_o,
    output logic                       pwrite_o,
    output logic [DES_ADDR_W-1:0]      paddr_o,
    output logic [31:0]                pwdata_o,
    output logic [3:0]                 pstrb_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0000_0000;
        pstrb_o   = 4'hF;
    end
    // request held until pready is seen, only then released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= w;
        paddr_o   <= a;
        pwdata_o  <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        rd = prdata_i;
        err = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule // des_host_model

// *** test/des_top_test.sv ***
// self-checking bench for des_top
// assumes des_host_model as apb master and the bound checker
module des_top_test
    import des_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, hirq_n, lirq_n, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, m;
    logic [3:0]  pstrb;
    logic [15:0] e;
    des_evt_t    evt;
    int          mismatches, n_compared, n;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    des_top u_des_top (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .evt_i(evt),
        .host_bus_irq_n_o(hirq_n), .local_bus_irq_n_o(lirq_n));
    des_host_model u_des_host_model (.clk_i(clk), .pready_i(pready), .prdata_i(prdata),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] st_of(input logic [15:0] v);
        return {v[15:5], |v[4:2], v[1:0], 2'b00};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_des_host_model.xfer(1'b1, a, d, rd, err);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        u_des_host_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp, msg);
        chk({31'h0, err}, 32'h0, msg);
    endtask
    task pulse(input logic [15:0] v);
        @(posedge clk);
        evt <= des_evt_t'(v);
        @(posedge clk);
        evt <= '0;
    endtask
    task irq_chk(input logic h, input logic l, input string msg);
        @(negedge clk);
        chk({30'h0, hirq_n, lirq_n}, {30'h0, h, l}, msg);
    endtask
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #2000000;
        mismatches++;
        stop_test;
    end
    initial begin
        rst_n = 1'b0;
        evt = '0;
        mismatches = 0;
        n_compared = 0;
        void'($urandom(61095));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(DES_OFF_MASK, 32'h0, "mask reset");
        rd_chk(DES_OFF_STATUS, 32'h0, "status reset");
        irq_chk(1'b1, 1'b1, "irq after reset");
        wr(DES_OFF_MASK, 32'hFFFF_FFFF);
        rd_chk(DES_OFF_MASK, 32'h0000_FFFC, "mask rw");
        $display("test reset and mask done");
        wr(DES_OFF_QCTRL, 32'h0000_0100);
        rd_chk(DES_OFF_QCTRL, 32'h0000_0100, "qctrl rw");
        for (int i = 0; i < 16; i++) begin
            pulse(16'h0001 << i);
            irq_chk(1'b0, 1'b0, "irq on event");
            rd_chk(DES_OFF_STATUS, {16'h0, st_of(16'h0001 << i)}, "event bit");
            rd_chk(DES_OFF_STATUS, 32'h0, "read clears");
            irq_chk(1'b1, 1'b1, "irq cleared");
        end
        wr(DES_OFF_QCTRL, 32'h0);
        pulse(16'h1000);
        irq_chk(1'b0, 1'b1, "local off");
        rd_chk(DES_OFF_STATUS, 32'h0000_1000, "underflow");
        pulse(16'h8000);
        wr(DES_OFF_STATUS, 32'h0000_8000);
        rd_chk(DES_OFF_STATUS, 32'h0, "write one clears");
        $display("test single events done");
        n = $urandom_range(7, 1);
        wr(DES_OFF_QCTRL, n | (n << 4));
        rd_chk(DES_OFF_QCTRL, n | (n << 4), "threshold rw");
        repeat ((1 << n) - 1) pulse(16'h4400);
        rd_chk(DES_OFF_STATUS, 32'h0, "below threshold");
        pulse(16'h4400);
        rd_chk(DES_OFF_STATUS, 32'h0000_4400, "at threshold");
        wr(DES_OFF_QCTRL, 32'h0);
        $display("test threshold done");
        repeat (40) begin
            m = $urandom;
            e = 16'($urandom);
            wr(DES_OFF_MASK, m);
            pulse(e);
            irq_chk(~|(st_of(e) & m[15:0]), 1'b1, "random irq");
            rd_chk(DES_OFF_PENDING, {16'h0, st_of(e) & m[15:0]}, "random pending");
            rd_chk(DES_OFF_STATUS, {16'h0, st_of(e)}, "random status");
        end
        $display("test random done");
        u_des_host_model.xfer(1'b0, 8'h10, 32'h0, rd, err);
        chk(rd, 32'h0, "unmapped read data");
        chk({31'h0, err}, 32'h1, "unmapped read error");
        $display("test unmapped done");
        stop_test;
    end
endmodule // des_top_test
